// [gate_drive_pkg.sv]
package gate_drive_pkg;
  // Register map
  localparam logic [5:0] ADDR_BRIDGE8_DRIVE_CURRENT = 6'h16;
  localparam logic [5:0] ADDR_LOW_CURRENT_SELECT    = 6'h17;
  localparam logic [7:0] RST_BRIDGE8_DRIVE_CURRENT  = 8'hFF;
  localparam logic [7:0] RST_LOW_CURRENT_SELECT     = 8'h00;
  // Field positions
  localparam int SOURCE_MSB = 7;
  localparam int SOURCE_LSB = 4;
  localparam int SINK_MSB   = 3;
  localparam int SINK_LSB   = 0;
  localparam int NUM_BRIDGES = 8;
  localparam int BRIDGE8_IDX = 7;
  // Current levels in microamperes
  localparam int LEVEL_W = 16;
  typedef logic [LEVEL_W-1:0] level_t;
  typedef enum logic [0:0] {
    TABLE_STANDARD = 1'b0,
    TABLE_ULTRA_LOW = 1'b1
  } table_sel_t;

  function automatic level_t decode_level(input logic [3:0] code,
                                          input table_sel_t tsel);
    level_t std_ua;
    level_t low_ua;
    std_ua = 16'h0000;
    low_ua = 16'h0000;
    unique case (code)
      4'h0: begin std_ua = 16'h01F4; low_ua = 16'h0032; end
      4'h1: begin std_ua = 16'h03E8; low_ua = 16'h006E; end
      4'h2: begin std_ua = 16'h07D0; low_ua = 16'h00AA; end
      4'h3: begin std_ua = 16'h0BB8; low_ua = 16'h00E6; end
      4'h4: begin std_ua = 16'h0FA0; low_ua = 16'h0122; end
      4'h5: begin std_ua = 16'h1388; low_ua = 16'h015E; end
      4'h6: begin std_ua = 16'h1770; low_ua = 16'h019A; end
      4'h7: begin std_ua = 16'h1B58; low_ua = 16'h0258; end
      4'h8: begin std_ua = 16'h1F40; low_ua = 16'h02D5; end
      4'h9: begin std_ua = 16'h2EE0; low_ua = 16'h0352; end
      4'hA: begin std_ua = 16'h3E80; low_ua = 16'h03E8; end
      4'hB: begin std_ua = 16'h4E20; low_ua = 16'h04B0; end
      4'hC: begin std_ua = 16'h5DC0; low_ua = 16'h0578; end
      4'hD: begin std_ua = 16'h7918; low_ua = 16'h0640; end
      4'hE: begin std_ua = 16'hBB80; low_ua = 16'h0708; end
      4'hF: begin std_ua = 16'hF230; low_ua = 16'h08FC; end
    endcase
    return (tsel == TABLE_ULTRA_LOW) ? low_ua : std_ua;
  endfunction
endpackage

// [drive_level_decode.sv]
`timescale 1ns/1ns
module drive_level_decode
  import gate_drive_pkg::*;
(
  // Code and table choice
  input  wire logic [3:0] i_code,
  input  wire logic       i_low_sel,
  // Decoded level in microamperes
  output logic [LEVEL_W-1:0] o_level_ua
);
  always_comb begin
    o_level_ua = decode_level(i_code, table_sel_t'(i_low_sel));
  end
endmodule

// [gate_drive_current_config.sv]
`timescale 1ns/1ns
// How it works
// - Register 0x16 resets to 0xFF and sets half-bridge 8 currents.
// - Bits 7 to 4 of it are the source code, reset all ones.
// - Bits 3 to 0 of it are the sink code, reset all ones.
// - Standard table runs 0.5 mA to 62 mA, 3 mA at code 3.
// - Ultra-low table runs 50 uA to 2.3 mA for the same codes.
// - Register 0x17 resets to zero and holds eight low selects.
// - Bit 7 is half-bridge 1 down to bit 0 for half-bridge 8.
// - Select 0 decodes with standard table, 1 with ultra-low table.
module gate_drive_current_config
  import gate_drive_pkg::*;
(
  // Clock and reset
  input  wire logic               i_ref_clk,
  input  wire logic               i_rst,
  // Register port from the serial interface
  input  wire logic               i_reg_wr,
  input  wire logic [5:0]         i_reg_addr,
  input  wire logic [7:0]         i_reg_wdata,
  output logic      [7:0]         o_reg_rdata,
  output logic                    o_reg_hit,
  // Register fields
  output logic      [3:0]         o_bridge8_source_code,
  output logic      [3:0]         o_bridge8_sink_code,
  output logic      [NUM_BRIDGES-1:0] o_bridge_low_select,
  // Decoded bridge 8 levels
  output logic      [LEVEL_W-1:0] o_bridge8_source_ua,
  output logic      [LEVEL_W-1:0] o_bridge8_sink_ua
);
  logic [7:0] drive_current_reg;
  logic [7:0] drive_current_next;
  logic [7:0] low_select_reg;
  logic [7:0] low_select_next;
  logic       bridge8_low_select;

  // Anchor codes and levels for the checks below
  localparam level_t     LEVEL_STD_BOTTOM = 16'h01F4;
  localparam level_t     LEVEL_STD_THREE  = 16'h0BB8;
  localparam level_t     LEVEL_STD_TOP    = 16'hF230;
  localparam level_t     LEVEL_LOW_BOTTOM = 16'h0032;
  localparam level_t     LEVEL_LOW_TOP    = 16'h08FC;
  localparam logic [3:0] CODE_BOTTOM      = 4'h0;
  localparam logic [3:0] CODE_THREE       = 4'h3;
  localparam logic [3:0] CODE_TOP         = 4'hF;

  always_comb begin
    drive_current_next = drive_current_reg;
    low_select_next    = low_select_reg;
    if (i_reg_wr && i_reg_addr == ADDR_BRIDGE8_DRIVE_CURRENT) begin
      drive_current_next = i_reg_wdata;
    end
    if (i_reg_wr && i_reg_addr == ADDR_LOW_CURRENT_SELECT) begin
      low_select_next = i_reg_wdata;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      drive_current_reg <= RST_BRIDGE8_DRIVE_CURRENT;
      low_select_reg    <= RST_LOW_CURRENT_SELECT;
    end else begin
      drive_current_reg <= drive_current_next;
      low_select_reg    <= low_select_next;
    end
  end

  // Combinational read
  always_comb begin
    o_reg_rdata = 8'h00;
    o_reg_hit   = 1'b0;
    unique case (i_reg_addr)
      ADDR_BRIDGE8_DRIVE_CURRENT: begin
        o_reg_rdata = drive_current_reg;
        o_reg_hit   = 1'b1;
      end
      ADDR_LOW_CURRENT_SELECT: begin
        o_reg_rdata = low_select_reg;
        o_reg_hit   = 1'b1;
      end
      default: begin
        o_reg_rdata = 8'h00;
        o_reg_hit   = 1'b0;
      end
    endcase
  end

  // Bit 7 is bridge 1, bit 0 bridge 8; output index n-1 is bridge n
  always_comb begin
    for (int i = 0; i < NUM_BRIDGES; i++) begin
      o_bridge_low_select[i] = low_select_reg[NUM_BRIDGES-1-i];
    end
  end
  assign bridge8_low_select = o_bridge_low_select[BRIDGE8_IDX];

  assign o_bridge8_source_code = drive_current_reg[SOURCE_MSB:SOURCE_LSB];
  assign o_bridge8_sink_code   = drive_current_reg[SINK_MSB:SINK_LSB];

  drive_level_decode u_source_dec (
    .i_code     (o_bridge8_source_code),
    .i_low_sel  (bridge8_low_select),
    .o_level_ua (o_bridge8_source_ua)
  );

  drive_level_decode u_sink_dec (
    .i_code     (o_bridge8_sink_code),
    .i_low_sel  (bridge8_low_select),
    .o_level_ua (o_bridge8_sink_ua)
  );

  property p_reset_values;
    @(posedge i_ref_clk) i_rst |=>
      drive_current_reg == RST_BRIDGE8_DRIVE_CURRENT &&
      low_select_reg == RST_LOW_CURRENT_SELECT;
  endproperty
  a_reset_values: assert property (p_reset_values)
    else $error("Reset values wrong");

  property p_write_dc;
    @(posedge i_ref_clk) disable iff (i_rst)
      i_reg_wr && i_reg_addr == ADDR_BRIDGE8_DRIVE_CURRENT |=>
      o_bridge8_source_code == $past(i_reg_wdata[SOURCE_MSB:SOURCE_LSB]) &&
      o_bridge8_sink_code == $past(i_reg_wdata[SINK_MSB:SINK_LSB]);
  endproperty
  a_write_dc: assert property (p_write_dc)
    else $error("Drive current write lost");

  property p_write_ls;
    @(posedge i_ref_clk) disable iff (i_rst)
      i_reg_wr && i_reg_addr == ADDR_LOW_CURRENT_SELECT |=>
      o_bridge_low_select[0] == $past(i_reg_wdata[7]) &&
      o_bridge_low_select[7] == $past(i_reg_wdata[0]);
  endproperty
  a_write_ls: assert property (p_write_ls)
    else $error("Low select bit order wrong");

  property p_hold;
    @(posedge i_ref_clk) disable iff (i_rst)
      !i_reg_wr |=> $stable(drive_current_reg) && $stable(low_select_reg);
  endproperty
  a_hold: assert property (p_hold)
    else $error("Register changed without write");

  property p_std_top;
    @(posedge i_ref_clk) disable iff (i_rst)
      !bridge8_low_select && o_bridge8_source_code == CODE_TOP |->
      o_bridge8_source_ua == LEVEL_STD_TOP;
  endproperty
  a_std_top: assert property (p_std_top)
    else $error("Standard top level wrong");

  property p_std_three;
    @(posedge i_ref_clk) disable iff (i_rst)
      !bridge8_low_select && o_bridge8_sink_code == CODE_THREE |->
      o_bridge8_sink_ua == LEVEL_STD_THREE;
  endproperty
  a_std_three: assert property (p_std_three)
    else $error("Standard code 3 level wrong");

  property p_low_bottom;
    @(posedge i_ref_clk) disable iff (i_rst)
      bridge8_low_select && o_bridge8_sink_code == CODE_BOTTOM |->
      o_bridge8_sink_ua == LEVEL_LOW_BOTTOM;
  endproperty
  a_low_bottom: assert property (p_low_bottom)
    else $error("Ultra-low bottom level wrong");

  property p_low_cap;
    @(posedge i_ref_clk) disable iff (i_rst)
      bridge8_low_select |->
      o_bridge8_source_ua <= LEVEL_LOW_TOP &&
      o_bridge8_sink_ua <= LEVEL_LOW_TOP;
  endproperty
  a_low_cap: assert property (p_low_cap)
    else $error("Ultra-low table not used");

  // Write then idle read of the same register
  sequence s_select_write;
    i_reg_wr && i_reg_addr == ADDR_LOW_CURRENT_SELECT;
  endsequence

  sequence s_select_read;
    !i_reg_wr && i_reg_addr == ADDR_LOW_CURRENT_SELECT;
  endsequence

  sequence s_drive_write;
    i_reg_wr && i_reg_addr == ADDR_BRIDGE8_DRIVE_CURRENT;
  endsequence

  sequence s_drive_read;
    !i_reg_wr && i_reg_addr == ADDR_BRIDGE8_DRIVE_CURRENT;
  endsequence

  property p_readback;
    @(posedge i_ref_clk) disable iff (i_rst)
      s_select_write ##1 s_select_read |->
      o_reg_rdata == $past(i_reg_wdata);
  endproperty
  a_readback: assert property (p_readback)
    else $error("Readback mismatch");

  property p_readback_dc;
    @(posedge i_ref_clk) disable iff (i_rst)
      s_drive_write ##1 s_drive_read |->
      o_reg_rdata == $past(i_reg_wdata);
  endproperty
  a_readback_dc: assert property (p_readback_dc)
    else $error("Drive current readback mismatch");

  property p_ignore_unmapped;
    @(posedge i_ref_clk) disable iff (i_rst)
      i_reg_wr && i_reg_addr != ADDR_BRIDGE8_DRIVE_CURRENT &&
      i_reg_addr != ADDR_LOW_CURRENT_SELECT |=>
      $stable(drive_current_reg) && $stable(low_select_reg);
  endproperty
  a_ignore_unmapped: assert property (p_ignore_unmapped)
    else $error("Unmapped write changed a register");

  property p_unmapped_read;
    @(posedge i_ref_clk) disable iff (i_rst)
      i_reg_addr != ADDR_BRIDGE8_DRIVE_CURRENT &&
      i_reg_addr != ADDR_LOW_CURRENT_SELECT |->
      o_reg_rdata == 8'h00 && !o_reg_hit;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read)
    else $error("Unmapped read not zero");

  property p_low_top;
    @(posedge i_ref_clk) disable iff (i_rst)
      bridge8_low_select && o_bridge8_source_code == CODE_TOP |->
      o_bridge8_source_ua == LEVEL_LOW_TOP;
  endproperty
  a_low_top: assert property (p_low_top)
    else $error("Ultra-low top level wrong");

  property p_std_bottom;
    @(posedge i_ref_clk) disable iff (i_rst)
      !bridge8_low_select && o_bridge8_sink_code == CODE_BOTTOM |->
      o_bridge8_sink_ua == LEVEL_STD_BOTTOM;
  endproperty
  a_std_bottom: assert property (p_std_bottom)
    else $error("Standard bottom level wrong");
endmodule

// [host_model.sv]
`timescale 1ns/1ns
module host_model (
  // Clock
  input  wire logic       i_ref_clk,
  // Register port toward the device
  output logic            o_reg_wr,
  output logic      [5:0] o_reg_addr,
  output logic      [7:0] o_reg_wdata
);
  initial begin
    o_reg_wr    = 1'b0;
    o_reg_addr  = 6'h00;
    o_reg_wdata = 8'h00;
  end
  // One-cycle write strobe, changed at falling edges
  task automatic write_reg(input logic [5:0] a, input logic [7:0] d);
    @(negedge i_ref_clk);
    o_reg_wr    = 1'b1;
    o_reg_addr  = a;
    o_reg_wdata = d;
    @(negedge i_ref_clk);
    o_reg_wr    = 1'b0;
    o_reg_wdata = ~d;
  endtask
  // Read address for the combinational read port
  task automatic set_addr(input logic [5:0] a);
    @(negedge i_ref_clk);
    o_reg_addr = a;
  endtask
endmodule

// [testbench.sv]
`timescale 1ns/1ns
module testbench;
  import gate_drive_pkg::*;
  logic               i_ref_clk = 1'b0;
  logic               i_rst = 1'b1;
  logic               i_reg_wr;
  logic [5:0]         i_reg_addr;
  logic [7:0]         i_reg_wdata;
  logic [7:0]         o_reg_rdata;
  logic               o_reg_hit;
  logic [3:0]         src;
  logic [3:0]         snk;
  logic [7:0]         lsel;
  logic [LEVEL_W-1:0] src_ua;
  logic [LEVEL_W-1:0] snk_ua;
  int fails = 0;
  int comparisons = 0;
  int seed = 97;
  int m16;
  int m17;
  int rv;
  int std_t[16] = '{500, 1000, 2000, 3000, 4000, 5000, 6000, 7000, 8000,
                    12000, 16000, 20000, 24000, 31000, 48000, 62000};
  int low_t[16] = '{50, 110, 170, 230, 290, 350, 410, 600, 725, 850,
                    1000, 1200, 1400, 1600, 1800, 2300};
  always #20 i_ref_clk = ~i_ref_clk;
  host_model host_model_i (
    .i_ref_clk(i_ref_clk), .o_reg_wr(i_reg_wr),
    .o_reg_addr(i_reg_addr), .o_reg_wdata(i_reg_wdata));
  gate_drive_current_config gate_drive_current_config_i (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_reg_wr(i_reg_wr),
    .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
    .o_reg_rdata(o_reg_rdata), .o_reg_hit(o_reg_hit),
    .o_bridge8_source_code(src), .o_bridge8_sink_code(snk),
    .o_bridge_low_select(lsel), .o_bridge8_source_ua(src_ua),
    .o_bridge8_sink_ua(snk_ua));
  task automatic results();
    if (fails == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %0h seen %0h", n, e, g);
    end
  endtask
  // Model update, then the bus write
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    if (a == ADDR_BRIDGE8_DRIVE_CURRENT) m16 = d;
    if (a == ADDR_LOW_CURRENT_SELECT) m17 = d;
    host_model_i.write_reg(a, d);
  endtask
  task automatic check_all();
    logic [7:0] rev;
    int exp_src;
    int exp_snk;
    for (int i = 0; i < 8; i++) rev[i] = m17[7-i];
    exp_src = m17[0] ? low_t[m16 >> 4] : std_t[m16 >> 4];
    exp_snk = m17[0] ? low_t[m16 & 15] : std_t[m16 & 15];
    host_model_i.set_addr(ADDR_BRIDGE8_DRIVE_CURRENT);
    #1 chk("rdata16", m16, o_reg_rdata);
    chk("hit16", 1, o_reg_hit);
    chk("src", m16 >> 4, src);
    chk("snk", m16 & 15, snk);
    chk("lsel", rev, lsel);
    chk("src_ua", exp_src, src_ua);
    chk("snk_ua", exp_snk, snk_ua);
    host_model_i.set_addr(ADDR_LOW_CURRENT_SELECT);
    #1 chk("rdata17", m17, o_reg_rdata);
  endtask
  initial begin
    #4000000;
    fails++;
    results();
  end
  initial begin
    m16 = 8'hFF;
    m17 = 0;
    repeat (5) @(negedge i_ref_clk);
    i_rst = 1'b0;
    check_all();
    for (int i = 0; i < 32; i++) begin
      rv = $random(seed);
      wr(ADDR_BRIDGE8_DRIVE_CURRENT, {i[3:0], ~i[3:0]});
      wr(ADDR_LOW_CURRENT_SELECT, {rv[7:1], i[4]});
      check_all();
    end
    foreach (std_t[i]) begin
      rv = $random(seed);
      wr(6'h15 ^ i[5:0] ^ {i[0], 5'h00}, rv[7:0]);
      host_model_i.set_addr(6'h18 + i[5:0]);
      #1 chk("rdata_unmapped", 0, o_reg_rdata);
      chk("hit_unmapped", 0, o_reg_hit);
      check_all();
    end
    @(negedge i_ref_clk);
    i_rst = 1'b1;
    @(negedge i_ref_clk);
    i_rst = 1'b0;
    m16 = 8'hFF;
    m17 = 0;
    check_all();
    results();
  end
endmodule
